// ### design/ocs_map.svh
// Register offsets, field positions, reset values and timing counts of the chop sequencer.
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OCS_CTRL_OFS      8'h00
`define OCS_DRATE_OFS     8'h04
`define OCS_CMD_OFS       8'h08
`define OCS_PERIOD_OFS    8'h0C
`define OCS_DELAY_OFS     8'h10
`define OCS_STATUS_OFS    8'h14
`define OCS_RESULT_OFS    8'h18
// ****************************************************************
// Field positions
// ****************************************************************
`define OCS_CONT_BIT      0
`define OCS_LOWLAT_BIT    4
`define OCS_CHOP_BIT      5
`define OCS_START_BIT     0
`define OCS_STOP_BIT      1
`define OCS_BUSY_BIT      0
`define OCS_POL_BIT       1
`define OCS_READY_BIT     2
// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define OCS_DRATE_RST     8'h10
`define OCS_PERIOD_RST    24'h00_0068
`define OCS_DELAY_RST     16'h000E
`define OCS_MOD_DIV       16
`define OCS_SINC3_SETTLE  3
`endif

// ### design/ocs_pkg.sv
// Types shared by the offset chop conversion sequencer.
package ocs_pkg;
  typedef enum logic [2:0] {
    OCS_IDLE  = 3'b001,
    OCS_DELAY = 3'b010,
    OCS_CONV  = 3'b100
  } ocs_state_e;
  typedef logic signed [15:0] ocs_sample_t;
endpackage : ocs_pkg

// ### design/ocs_sequencer.sv
// Offset chop conversion sequencer with an Avalon-MM register slave.
//
// Operation
// R1: Chop enable bit in data rate register.
// R2: First conversion of pair uses normal polarity.
// R3: Swap polarity, then convert with inputs reversed.
// R4: Output mean of normal and reversed conversions.
// R5: Low-latency chop: first result after two conversions.
// R6: Sinc3 chop: first result after six conversions.
// R7: Continuous chop: later results take half time.
// R8: Continuous chop pipelines alternating polarity conversions.
// R9: Low-latency chop first result is twice later.
// R10: Modulator period is sixteen master clocks.
// R11: Settling delay applies to both pair conversions; continuous chop applies it only to the first pair.
// R12: Start on start pin rise or command.
// R13: Chop off: normal polarity, direct output.
//
// The Avalon-MM slave port and the address map were decided locally.
`include "ocs_map.svh"
module ocs_sequencer #(
  parameter int PERIOD_W = 24
) (
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_n_in,
  // Avalon-MM slave
  input  wire logic [7:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  output logic [31:0]             avs_readdata_out,
  output logic                    avs_waitrequest_out,
  // Converter side
  input  wire logic               start_pin_in,
  input  wire ocs_pkg::ocs_sample_t raw_data_in,
  output logic                    polarity_swap_out,
  output logic                    conv_active_out,
  output logic                    result_valid_out,
  output ocs_pkg::ocs_sample_t    result_out
);
  import ocs_pkg::*;

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic                ack_q, ack_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                cont_q, cont_d;
  logic [7:0]          drate_q, drate_d;
  logic [PERIOD_W-1:0] period_q, period_d;
  logic [15:0]         delay_q, delay_d;
  logic                ready_q, ready_d;
  logic                wr_go, rd_go, cmd_start, cmd_stop;
  logic [31:0]         rd_mux;

  // Every access takes one wait state, so read data always come from a flop.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out    = rdata_q;
  assign wr_go     = avs_write_in & ack_q;
  assign rd_go     = avs_read_in & ack_q;
  assign cmd_start = wr_go && avs_address_in == `OCS_CMD_OFS && avs_writedata_in[`OCS_START_BIT];
  assign cmd_stop  = wr_go && avs_address_in == `OCS_CMD_OFS && avs_writedata_in[`OCS_STOP_BIT];

  ocs_state_e          st_q, st_d;
  logic                pol_q, pol_d;
  logic                res_v_q, res_v_d;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_in)
      `OCS_CTRL_OFS:   rd_mux[`OCS_CONT_BIT] = cont_q;
      `OCS_DRATE_OFS:  rd_mux[7:0] = drate_q;
      `OCS_PERIOD_OFS: rd_mux[PERIOD_W-1:0] = period_q;
      `OCS_DELAY_OFS:  rd_mux[15:0] = delay_q;
      `OCS_STATUS_OFS: rd_mux[2:0] = {ready_q, pol_q, st_q != OCS_IDLE};
      `OCS_RESULT_OFS: rd_mux = {{16{result_out[15]}}, result_out};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    ack_d    = (avs_read_in | avs_write_in) & ~ack_q;
    rdata_d  = (avs_read_in & ~ack_q) ? rd_mux : rdata_q;
    cont_d   = cont_q;
    drate_d  = drate_q;
    period_d = period_q;
    delay_d  = delay_q;
    if (wr_go) begin
      case (avs_address_in)
        `OCS_CTRL_OFS:   cont_d = avs_writedata_in[`OCS_CONT_BIT];
        `OCS_DRATE_OFS:  drate_d = avs_writedata_in[7:0]; // [R1]
        `OCS_PERIOD_OFS: period_d = avs_writedata_in[PERIOD_W-1:0];
        `OCS_DELAY_OFS:  delay_d = avs_writedata_in[15:0];
        default:         ;
      endcase
    end
    // A new result sets ready even in the cycle a result read clears it.
    ready_d = (ready_q & ~(rd_go && avs_address_in == `OCS_RESULT_OFS)) | res_v_d;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      cont_q   <= 1'b0;
      drate_q  <= `OCS_DRATE_RST;
      period_q <= PERIOD_W'(`OCS_PERIOD_RST);
      delay_q  <= `OCS_DELAY_RST;
      ready_q  <= 1'b0;
    end else begin
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      cont_q   <= cont_d;
      drate_q  <= drate_d;
      period_q <= period_d;
      delay_q  <= delay_d;
      ready_q  <= ready_d;
    end
  end

  // ****************************************************************
  // Start pin synchroniser and modulator clock divider
  // ****************************************************************
  logic [2:0] pin_q, pin_d;
  logic       pin_lvl_q, pin_lvl_d;
  logic [3:0] pre_q, pre_d;
  logic       tick, pin_rise, go;

  always_comb begin
    pin_d     = {pin_q[1:0], start_pin_in};
    pin_lvl_d = (pin_q[1] == pin_q[2]) ? pin_q[2] : pin_lvl_q;
    pre_d     = pre_q + 4'h1; // [R10]
  end
  assign pin_rise = (pin_q[1] == pin_q[2]) && pin_q[2] && !pin_lvl_q; // [R12]
  assign tick     = (pre_q == 4'(`OCS_MOD_DIV - 1)); // [R10]
  assign go       = pin_rise | cmd_start; // [R12]

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_q     <= 3'b000;
      pin_lvl_q <= 1'b0;
      pre_q     <= 4'h0;
    end else begin
      pin_q     <= pin_d;
      pin_lvl_q <= pin_lvl_d;
      pre_q     <= pre_d;
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  logic        chop_q, chop_d;
  logic        sinc_q, sinc_d;
  logic        run_q, run_d;
  logic        half_q, half_d;
  logic        first_q, first_d;
  logic [31:0] cnt_q, cnt_d;
  ocs_sample_t s_norm_q, s_norm_d, s_rev_q, s_rev_d, res_q, res_d;
  logic [31:0] target;
  logic        conv_end;

  function automatic ocs_sample_t mean2(input ocs_sample_t a, input ocs_sample_t b);
    logic signed [16:0] sum;
    sum   = 17'(a) + 17'(b);
    mean2 = sum[16:1];
  endfunction

  // Sinc3 needs three conversions to settle after each start or swap.
  assign target = (sinc_q && (chop_q || first_q))
                  ? 32'(`OCS_SINC3_SETTLE) * 32'(period_q) : 32'(period_q); // [R6]
  assign conv_end = (st_q == OCS_CONV) && tick && (cnt_q == target - 32'd1);

  always_comb begin
    st_d     = st_q;
    chop_d   = chop_q;
    sinc_d   = sinc_q;
    run_d    = run_q;
    half_d   = half_q;
    first_d  = first_q;
    cnt_d    = cnt_q;
    pol_d    = pol_q;
    s_norm_d = s_norm_q;
    s_rev_d  = s_rev_q;
    res_d    = res_q;
    res_v_d  = 1'b0;
    if (tick && st_q != OCS_IDLE) begin
      cnt_d = cnt_q + 32'd1;
    end
    case (st_q)
      OCS_IDLE: begin
        if (go) begin
          chop_d  = drate_q[`OCS_CHOP_BIT]; // [R1]
          sinc_d  = ~drate_q[`OCS_LOWLAT_BIT];
          run_d   = cont_q;
          half_d  = 1'b0;
          first_d = 1'b1;
          pol_d   = 1'b0; // [R2]
          cnt_d   = 32'd0;
          st_d    = OCS_DELAY;
        end
      end
      OCS_DELAY: begin
        if (tick && cnt_q >= 32'(delay_q) - 32'd1) begin
          cnt_d = 32'd0;
          st_d  = OCS_CONV;
        end
      end
      OCS_CONV: begin
        if (conv_end) begin
          cnt_d   = 32'd0;
          first_d = 1'b0;
          if (pol_q) begin
            s_rev_d = raw_data_in;
          end else begin
            s_norm_d = raw_data_in;
          end
          if (!chop_q) begin
            res_d   = raw_data_in; // [R13]
            res_v_d = 1'b1;
          end else if (pol_q || half_q) begin
            res_d   = pol_q ? mean2(s_norm_q, raw_data_in)
                            : mean2(raw_data_in, s_rev_q); // [R4] [R8]
            res_v_d = 1'b1;
          end
          if (chop_q) begin
            pol_d = ~pol_q; // [R3] [R8]
          end
          if (chop_q && !pol_q && !half_q) begin
            st_d = OCS_DELAY; // [R11] [R5] [R9]
          end else if (run_q) begin
            half_d = chop_q;
            st_d   = OCS_CONV; // [R7]
          end else begin
            pol_d = 1'b0;
            st_d  = OCS_IDLE;
          end
        end
      end
      default: st_d = OCS_IDLE;
    endcase
    if (cmd_stop) begin
      pol_d = 1'b0;
      st_d  = OCS_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_q     <= OCS_IDLE;
      chop_q   <= 1'b0;
      sinc_q   <= 1'b0;
      run_q    <= 1'b0;
      half_q   <= 1'b0;
      first_q  <= 1'b0;
      cnt_q    <= 32'd0;
      pol_q    <= 1'b0;
      s_norm_q <= 16'sh0000;
      s_rev_q  <= 16'sh0000;
      res_q    <= 16'sh0000;
      res_v_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      chop_q   <= chop_d;
      sinc_q   <= sinc_d;
      run_q    <= run_d;
      half_q   <= half_d;
      first_q  <= first_d;
      cnt_q    <= cnt_d;
      pol_q    <= pol_d;
      s_norm_q <= s_norm_d;
      s_rev_q  <= s_rev_d;
      res_q    <= res_d;
      res_v_q  <= res_v_d;
    end
  end

  assign polarity_swap_out = pol_q;
  assign conv_active_out   = (st_q != OCS_IDLE);
  assign result_valid_out  = res_v_q;
  assign result_out        = res_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_TICK_SPACING: assert property (tick |=> !tick ##15 tick) // [R10]
    else $error("Modulator tick not every sixteen clocks.");
  AST_START_TAKEN: assert property (st_q == OCS_IDLE && go && !cmd_stop
                                    |=> st_q == OCS_DELAY && !pol_q) // [R12]
    else $error("Start did not begin a normal polarity sequence.");
  AST_NORMAL_FIRST: assert property (st_q == OCS_DELAY && first_q |-> !pol_q) // [R2]
    else $error("First conversion not at normal polarity.");
  AST_SWAP: assert property (conv_end && chop_q && !pol_q && !cmd_stop |=> pol_q) // [R3]
    else $error("Polarity not swapped after normal conversion.");
  AST_MEAN: assert property (res_v_q && chop_q
                             |-> res_q == mean2(s_norm_q, s_rev_q)) // [R4]
    else $error("Chopped result is not the pair mean.");
  AST_FIRST_PAIR_DELAY: assert property (conv_end && chop_q && !pol_q && !half_q && !cmd_stop
                                         |=> st_q == OCS_DELAY && !res_v_q) // [R11]
    else $error("Reversed conversion skipped the settling delay.");
  AST_CONT_HALF: assert property (conv_end && run_q && chop_q && pol_q && !cmd_stop
                                  |=> st_q == OCS_CONV && half_q) // [R7]
    else $error("Continuous chop did not pipeline the next conversion.");
  AST_PIPE_RESULT: assert property (conv_end && half_q && !cmd_stop |=> res_v_q) // [R8]
    else $error("Pipelined conversion gave no averaged result.");
  AST_NOCHOP_POL: assert property (!chop_q |-> !pol_q) // [R13]
    else $error("Polarity swapped with chop disabled.");
  AST_NOCHOP_DIRECT: assert property (conv_end && !chop_q && !cmd_stop
                                      |=> res_v_q && res_q == $past(raw_data_in)) // [R13]
    else $error("Unchopped conversion not output directly.");
  AST_CONV_LEN: assert property (conv_end |-> cnt_q == target - 32'd1) // [R5] [R6] [R9]
    else $error("Conversion ended at the wrong period count.");
  AST_CHOP_CFG: assert property (wr_go && avs_address_in == `OCS_DRATE_OFS
                                 |=> drate_q[`OCS_CHOP_BIT] == $past(avs_writedata_in[5])) // [R1]
    else $error("Chop enable write not stored.");

  COV_CHOP_SINGLE: cover property (res_v_q && chop_q && !run_q);
  COV_CHOP_CONT:   cover property (res_v_q && half_q);
  COV_NOCHOP:      cover property (res_v_q && !chop_q);
  COV_PIN_START:   cover property (pin_rise && st_q == OCS_IDLE);
endmodule : ocs_sequencer

// ### design/ocs_sequencer_unused_placeholder_never.sv
// Intentionally empty file holding no logic.

// ### tb/ocs_conv_model.sv
// Converter filter model that feeds samples to the chop sequencer.
module ocs_conv_model (
  // Clock and converter state
  input  wire logic                 ref_clk_in,
  input  wire logic                 polarity_swap_in,
  input  wire logic                 conv_active_in,
  // Settled values for each polarity
  input  wire ocs_pkg::ocs_sample_t norm_val_in,
  input  wire ocs_pkg::ocs_sample_t rev_val_in,
  // Filter output
  output ocs_pkg::ocs_sample_t      raw_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ocs_pkg::*;
  ocs_sample_t junk_q = 16'h5A5A;
  // Outside a conversion nothing is settled, so the output keeps moving.
  always @(posedge ref_clk_in) begin
    junk_q <= ~junk_q + 16'h0001;
  end
  assign raw_data_out = !conv_active_in ? junk_q :
                        polarity_swap_in ? rev_val_in : norm_val_in;
endmodule // ocs_conv_model

// ### tb/ocs_sequencer_tb_top.sv
// Self-checking testbench for the offset chop conversion sequencer.
`include "ocs_map.svh"
module ocs_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ocs_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdata      = 32'h0000_0000;
  logic        pin        = 1'b0;
  logic [31:0] rdata;
  logic        wait_r;
  logic        pol;
  logic        act;
  logic        vld;
  logic        pol_seen;
  ocs_sample_t raw;
  ocs_sample_t res;
  ocs_sample_t norm_v     = 16'h0000;
  ocs_sample_t rev_v      = 16'h0000;
  ocs_sample_t exp_q[$];
  logic [7:0]  dr_t[4]    = '{8'h10, 8'h00, 8'h30, 8'h20};
  int          n_t[4]     = '{6, 14, 12, 28};
  int          n_fail     = 0;
  int          compares   = 0;
  int          cyc        = 0;
  int          n_res      = 0;
  int          last_cyc   = 0;
  int          gap        = 0;

  ocs_sequencer #(.PERIOD_W(24)) DUT (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .start_pin_in(pin),
    .raw_data_in(raw), .polarity_swap_out(pol), .conv_active_out(act),
    .result_valid_out(vld), .result_out(res));

  ocs_conv_model conv_model (
    .ref_clk_in(ref_clk_in), .polarity_swap_in(pol), .conv_active_in(act),
    .norm_val_in(norm_v), .rev_val_in(rev_v), .raw_data_out(raw));

  always #20 ref_clk_in = ~ref_clk_in;

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (pol === 1'b1) pol_seen = 1'b1;
    if (rst_n_in === 1'b1 && vld === 1'b1) begin
      gap = cyc - last_cyc;
      last_cyc = cyc;
      n_res++;
      if (exp_q.size() == 0) check(32'h1, 32'h0, "extra result");
      else check(32'(res), 32'(exp_q.pop_front()), "result");
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One Avalon transfer; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge ref_clk_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    k = 0;
    // Waitrequest and read data are seen as they stood just before each rising edge.
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (wait_r !== 1'b0 && k < 50);
    if (k == 50) begin
      check(32'h0, 32'h1, "bus hang");
      results();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wait_res();
    int n0;
    int k;
    n0 = n_res;
    k = 0;
    while (n_res == n0 && k < 5000) begin
      @(posedge ref_clk_in);
      k++;
    end
    if (k == 5000) begin
      check(32'h0, 32'h1, "no result");
      results();
    end
  endtask

  // Starts by pin or command and checks the latency in modulator ticks.
  task automatic run(input logic use_pin, input int n);
    logic [31:0] q;
    int          t0;
    pol_seen = 1'b0;
    if (use_pin) begin
      @(posedge ref_clk_in);
      pin <= 1'b1;
      t0 = cyc;
      repeat (4) @(posedge ref_clk_in);
      pin <= 1'b0;
    end else begin
      bus(1'b1, `OCS_CMD_OFS, 32'h0000_0001, q);
      t0 = cyc;
    end
    wait_res();
    check(32'(last_cyc - t0 >= n * 16 - 16 && last_cyc - t0 <= n * 16 + 12), 1, "latency");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0]        q;
    logic signed [16:0] s;
    ocs_sample_t        e;
    void'($urandom(32'h2373));
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, `OCS_DRATE_OFS, 32'h0, q);
    check(q, 32'h0000_0010, "drate reset");
    bus(1'b0, `OCS_PERIOD_OFS, 32'h0, q);
    check(q, 32'h0000_0068, "period reset");
    bus(1'b0, `OCS_DELAY_OFS, 32'h0, q);
    check(q, 32'h0000_000E, "delay reset");
    bus(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0000_0000, "unmapped");
    // Short counts keep the run brief; expectations scale from them.
    bus(1'b1, `OCS_PERIOD_OFS, 32'h0000_0004, q);
    bus(1'b1, `OCS_DELAY_OFS, 32'h0000_0002, q);
    for (int i = 0; i < 4; i++) begin
      norm_v <= 16'($urandom);
      rev_v <= 16'($urandom);
      bus(1'b1, `OCS_DRATE_OFS, {24'h00_0000, dr_t[i]}, q);
      s = norm_v + rev_v;
      e = dr_t[i][`OCS_CHOP_BIT] ? s[16:1] : norm_v;
      exp_q.push_back(e);
      run(1'(i), n_t[i]);
      check(32'(pol_seen), 32'(dr_t[i][`OCS_CHOP_BIT]), "swap");
      bus(1'b0, `OCS_RESULT_OFS, 32'h0, q);
      check(q, {{16{e[15]}}, e}, "result reg");
    end
    bus(1'b1, `OCS_CTRL_OFS, 32'h0000_0001, q);
    bus(1'b1, `OCS_DRATE_OFS, 32'h0000_0030, q);
    repeat (4) exp_q.push_back(s[16:1]);
    run(1'b0, 12);
    for (int j = 0; j < 3; j++) begin
      wait_res();
      check(32'(gap), 32'd64, "cont gap");
    end
    bus(1'b1, `OCS_CMD_OFS, 32'h0000_0002, q);
    repeat (3) @(posedge ref_clk_in);
    check(32'(act), 32'h0, "stopped");
    check(32'(exp_q.size()), 32'h0, "pending");
    results();
  end
endmodule // ocs_sequencer_tb_top
